// [core/dmac_pkg.sv]
// package: constants and types for the damping mode actuator control
package dmac_pkg;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned BLINK_MS      = 500;
    localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned DEBOUNCE_MS   = 10;
    localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned DRIVE_MAX_MS  = 2000;
    localparam int unsigned DRIVE_MAX_CYC = CLK_HZ / 1000 * DRIVE_MAX_MS;
    localparam int unsigned UNDEF_MS      = 200;
    localparam int unsigned UNDEF_CYC     = CLK_HZ / 1000 * UNDEF_MS;
    localparam int unsigned CNT_W         = 32;
    localparam int unsigned RATE_W        = 16;

    // position switch codes {switch2, switch1}
    typedef enum logic [1:0] {
        DMAC_POS_UNDEF  = 2'h0,
        DMAC_POS_SOFT   = 2'h1,
        DMAC_POS_HARD   = 2'h2,
        DMAC_POS_MEDIUM = 2'h3
    } dmac_pos_t;

    typedef struct packed {
        logic touring_lamp;
        logic mode_a_lamp;
    } dmac_lamps_t;

    typedef struct packed {
        logic medium_req;
        logic hard_req;
    } dmac_auto_req_t;

    typedef struct packed {
        logic              dir_right;
        logic [RATE_W-1:0] edge_count;
    } dmac_steer_t;
endpackage : dmac_pkg

// [core/dmac_steer_decode.sv]
// steering rate sensor quadrature decoder
`timescale 1ns/1ps
`default_nettype none
module dmac_steer_decode (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic                  clock_en,
    input  wire logic                  phase_a,
    input  wire logic                  phase_b,
    output var  dmac_pkg::dmac_steer_t steer
);
    logic [1:0] a_sync_q;
    logic [1:0] b_sync_q;
    logic       a_prev_q;
    logic       b_prev_q;
    logic       step;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            a_sync_q <= 2'h0;
            b_sync_q <= 2'h0;
        end else if (clock_en) begin
            a_sync_q <= {a_sync_q[0], phase_a};
            b_sync_q <= {b_sync_q[0], phase_b};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            a_prev_q <= 1'h0;
            b_prev_q <= 1'h0;
        end else if (clock_en) begin
            a_prev_q <= a_sync_q[1];
            b_prev_q <= b_sync_q[1];
        end
    end

    assign step = (a_sync_q[1] ^ a_prev_q) | (b_sync_q[1] ^ b_prev_q);

    // quarter-cycle lead of one channel sets direction; edges give rate
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            steer <= '0;
        end else if (clock_en && step) begin
            steer.dir_right  <= a_prev_q ^ b_sync_q[1];
            steer.edge_count <= steer.edge_count + 16'h0001;
        end
    end
endmodule : dmac_steer_decode
`default_nettype wire

// [core/dmac_control.sv]
// damping mode selection, lamps and actuator position control
`timescale 1ns/1ps
`default_nettype none
module dmac_control #(
    parameter int unsigned DEBOUNCE_CYC  = dmac_pkg::DEBOUNCE_CYC,
    parameter int unsigned DRIVE_MAX_CYC = dmac_pkg::DRIVE_MAX_CYC,
    parameter int unsigned UNDEF_CYC     = dmac_pkg::UNDEF_CYC,
    parameter int unsigned BLINK_CYC     = dmac_pkg::BLINK_CYC
) (
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire logic                     clock_en,
    input  wire logic                     mode_switch,
    input  wire logic                     pos_switch1,
    input  wire logic                     pos_switch2,
    input  wire logic                     steer_phase_a,
    input  wire logic                     steer_phase_b,
    input  wire dmac_pkg::dmac_auto_req_t auto_req,
    input  wire logic                     fault_clear,
    output var  dmac_pkg::dmac_lamps_t    lamps,
    output var  logic                     motor_drive,
    output var  logic                     mode_a,
    output var  dmac_pkg::dmac_pos_t      position,
    output var  logic                     fault,
    output var  dmac_pkg::dmac_steer_t    steer
);
    typedef enum logic [2:0] {
        DMAC_IDLE  = 3'h1,
        DMAC_DRIVE = 3'h2,
        DMAC_FAIL  = 3'h4
    } dmac_state_t;

    // soft, hard, medium, hard, undefined along one turn; motor turns one way
    function automatic logic pos_is(input dmac_pkg::dmac_pos_t p,
                                    input dmac_pkg::dmac_pos_t t);
        return p == t;
    endfunction : pos_is

    logic [1:0]                  msw_sync_q;
    logic [1:0]                  psw1_sync_q;
    logic [1:0]                  psw2_sync_q;
    logic                        msw_stable_q;
    logic [dmac_pkg::CNT_W-1:0]  deb_cnt_q;
    logic                        press;
    dmac_pkg::dmac_pos_t         pos_now;
    dmac_pkg::dmac_pos_t         target_q;
    dmac_pkg::dmac_pos_t         target_d;
    dmac_state_t                 state_q;
    logic [dmac_pkg::CNT_W-1:0]  drive_cnt_q;
    logic [dmac_pkg::CNT_W-1:0]  undef_cnt_q;
    logic [dmac_pkg::CNT_W-1:0]  blink_cnt_q;
    logic                        blink_q;
    logic                        timeout;
    logic                        undef_long;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            msw_sync_q  <= 2'h0;
            // reads as soft until the pins are through: no drive at start
            psw1_sync_q <= 2'h3;
            psw2_sync_q <= 2'h0;
        end else if (clock_en) begin
            msw_sync_q  <= {msw_sync_q[0], mode_switch};
            psw1_sync_q <= {psw1_sync_q[0], pos_switch1};
            psw2_sync_q <= {psw2_sync_q[0], pos_switch2};
        end
    end

    // input must hold a new level for the whole debounce time
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            msw_stable_q <= 1'h0;
            deb_cnt_q    <= '0;
        end else if (clock_en) begin
            if (msw_sync_q[1] == msw_stable_q) begin
                deb_cnt_q <= '0;
            end else if (deb_cnt_q == DEBOUNCE_CYC - 1) begin
                msw_stable_q <= msw_sync_q[1];
                deb_cnt_q    <= '0;
            end else begin
                deb_cnt_q <= deb_cnt_q + 32'h1;
            end
        end
    end

    assign press = clock_en && !msw_stable_q && (msw_sync_q[1] == 1'h1)
                   && (deb_cnt_q == DEBOUNCE_CYC - 1);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_a <= 1'h0;
        end else if (press) begin
            mode_a <= !mode_a;
        end
    end

    assign pos_now = dmac_pkg::dmac_pos_t'({psw2_sync_q[1], psw1_sync_q[1]});

    always_comb begin
        if (mode_a) begin
            target_d = dmac_pkg::DMAC_POS_HARD;
        end else if (auto_req.hard_req) begin
            target_d = dmac_pkg::DMAC_POS_HARD;
        end else if (auto_req.medium_req) begin
            target_d = dmac_pkg::DMAC_POS_MEDIUM;
        end else begin
            target_d = dmac_pkg::DMAC_POS_SOFT;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            target_q <= dmac_pkg::DMAC_POS_SOFT;
        end else if (clock_en) begin
            target_q <= target_d;
        end
    end

    assign timeout    = drive_cnt_q >= DRIVE_MAX_CYC;
    assign undef_long = undef_cnt_q >= UNDEF_CYC;

    // fault latches until cleared; motor stays off to avoid overheating
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= DMAC_IDLE;
        end else if (clock_en) begin
            unique case (state_q)
                DMAC_IDLE: begin
                    if (!pos_is(pos_now, target_q)) begin
                        state_q <= DMAC_DRIVE;
                    end
                end
                DMAC_DRIVE: begin
                    if (timeout || undef_long) begin
                        state_q <= DMAC_FAIL;
                    end else if (pos_is(pos_now, target_q)) begin
                        state_q <= DMAC_IDLE;
                    end
                end
                DMAC_FAIL: begin
                    if (fault_clear) begin
                        state_q <= DMAC_IDLE;
                    end
                end
                default: state_q <= DMAC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            drive_cnt_q <= '0;
        end else if (clock_en) begin
            if (state_q == DMAC_DRIVE) begin
                drive_cnt_q <= drive_cnt_q + 32'h1;
            end else begin
                drive_cnt_q <= '0;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            undef_cnt_q <= '0;
        end else if (clock_en) begin
            if (pos_now == dmac_pkg::DMAC_POS_UNDEF && !undef_long) begin
                undef_cnt_q <= undef_cnt_q + 32'h1;
            end else if (pos_now != dmac_pkg::DMAC_POS_UNDEF) begin
                undef_cnt_q <= '0;
            end
        end
    end

    // single drive line fans out to all four actuators
    assign motor_drive = (state_q == DMAC_DRIVE);
    assign fault       = (state_q == DMAC_FAIL);
    assign position    = pos_now;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'h0;
        end else if (clock_en) begin
            if (!fault) begin
                blink_cnt_q <= '0;
                blink_q     <= 1'h1;
            end else if (blink_cnt_q == BLINK_CYC - 1) begin
                blink_cnt_q <= '0;
                blink_q     <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lamps <= '0;
        end else if (clock_en) begin
            if (fault) begin
                lamps.touring_lamp <= blink_q;
                lamps.mode_a_lamp  <= blink_q;
            end else begin
                lamps.touring_lamp <= !mode_a;
                lamps.mode_a_lamp  <= mode_a;
            end
        end
    end

    dmac_steer_decode u_steer (
        .clock    (clock),
        .reset_n  (reset_n),
        .clock_en (clock_en),
        .phase_a  (steer_phase_a),
        .phase_b  (steer_phase_b),
        .steer    (steer)
    );

    property p_reset_touring;
        @(posedge clock) $rose(reset_n) |-> (!mode_a && !motor_drive)
            ##1 !motor_drive [*2];
    endproperty
    a_reset_touring: assert property (p_reset_touring)
        else $error("mode or motor wrong after reset");

    property p_toggle;
        @(posedge clock) disable iff (!reset_n)
        press |=> mode_a != $past(mode_a);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("press did not toggle mode");

    property p_no_spurious;
        @(posedge clock) disable iff (!reset_n)
        !press |=> $stable(mode_a);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("mode changed without press");

    property p_stop_at_target;
        @(posedge clock) disable iff (!reset_n)
        (clock_en && motor_drive && pos_now == target_q) |=> !motor_drive;
    endproperty
    a_stop_at_target: assert property (p_stop_at_target)
        else $error("motor kept running at target");

    property p_mode_a_hard;
        @(posedge clock) disable iff (!reset_n)
        (clock_en && mode_a) |=> target_q == dmac_pkg::DMAC_POS_HARD;
    endproperty
    a_mode_a_hard: assert property (p_mode_a_hard)
        else $error("mode_a mode target not hard");

    property p_target_valid;
        @(posedge clock) disable iff (!reset_n)
        target_q != dmac_pkg::DMAC_POS_UNDEF;
    endproperty
    a_target_valid: assert property (p_target_valid)
        else $error("undefined target");

    property p_lamp_normal;
        @(posedge clock) disable iff (!reset_n)
        (clock_en && !fault) |=> lamps.mode_a_lamp == $past(mode_a)
            && lamps.touring_lamp == !$past(mode_a);
    endproperty
    a_lamp_normal: assert property (p_lamp_normal)
        else $error("lamp does not follow mode");

    property p_fault_stops;
        @(posedge clock) disable iff (!reset_n)
        (clock_en && fault && !fault_clear) |=> fault && !motor_drive;
    endproperty
    a_fault_stops: assert property (p_fault_stops)
        else $error("fault not held or motor driven during fault");

    property p_lamps_equal;
        @(posedge clock) disable iff (!reset_n)
        (clock_en && fault) ##1 (clock_en && fault)
            |=> lamps.touring_lamp == lamps.mode_a_lamp;
    endproperty
    a_lamps_equal: assert property (p_lamps_equal)
        else $error("lamps not blinking together");
endmodule : dmac_control
`default_nettype wire

// [verification/dmac_actuator_model.sv]
// actuator motor and encoder switch model for the damping control
`timescale 1ns/1ps
`default_nettype none
module dmac_actuator_model #(
    parameter int STEP_CYC = 50
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       motor_drive,
    input  wire logic       stuck,
    output var  logic       pos_switch1,
    output var  logic       pos_switch2,
    output var  logic [2:0] idx
);
    int cnt;
    // one revolution: soft, hard, medium, hard, undefined
    always_comb begin
        case (idx)
            3'h0:    {pos_switch2, pos_switch1} = 2'h1;
            3'h1:    {pos_switch2, pos_switch1} = 2'h2;
            3'h2:    {pos_switch2, pos_switch1} = 2'h3;
            3'h3:    {pos_switch2, pos_switch1} = 2'h2;
            default: {pos_switch2, pos_switch1} = 2'h0;
        endcase
    end
    // shaft only turns while driven; parks at soft after reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            idx <= 3'h0;
            cnt <= 0;
        end else if (!motor_drive || stuck) begin
            // stuck stands for a jammed shaft: driven but not turning
            cnt <= 0;
        end else if (cnt == STEP_CYC - 1) begin
            cnt <= 0;
            idx <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : dmac_actuator_model
`default_nettype wire

// [verification/damping_mode_actuator_control_test.sv]
// self-checking bench for the damping mode actuator control
`timescale 1ns/1ps
`default_nettype none
module damping_mode_actuator_control_test;
    localparam int LIMIT = 20000;
    localparam int DEB = 20;
    localparam int DRV = 400;
    localparam int UNDEF = 120;
    localparam int BLINK = 50;
    logic stuck = 1'b0;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clock_en = 1'b1;
    logic mode_switch = 1'b0;
    logic ph_a = 1'b0;
    logic ph_b = 1'b0;
    logic fault_clear = 1'b0;
    dmac_pkg::dmac_auto_req_t auto_req = '0;
    dmac_pkg::dmac_lamps_t    lamps;
    dmac_pkg::dmac_pos_t      position;
    dmac_pkg::dmac_steer_t    steer;
    logic       motor_drive, mode_a, fault, sw1, sw2;
    logic [2:0] idx;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    // short timing counts so debounce, limits and blinking fit the run
    dmac_control #(
        .DEBOUNCE_CYC(DEB), .DRIVE_MAX_CYC(DRV), .UNDEF_CYC(UNDEF),
        .BLINK_CYC(BLINK)
    ) DUT (
        .clock(clock), .reset_n(reset_n), .clock_en(clock_en),
        .mode_switch(mode_switch), .pos_switch1(sw1), .pos_switch2(sw2),
        .steer_phase_a(ph_a), .steer_phase_b(ph_b), .auto_req(auto_req),
        .fault_clear(fault_clear), .lamps(lamps),
        .motor_drive(motor_drive), .mode_a(mode_a), .position(position),
        .fault(fault), .steer(steer)
    );
    dmac_actuator_model MOTOR (
        .clock(clock), .reset_n(reset_n), .motor_drive(motor_drive),
        .pos_switch1(sw1), .pos_switch2(sw2), .idx(idx), .stuck(stuck)
    );

    initial begin
        forever #10 clock = ~clock;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // bounded wait for the motor output to reach a level
    task automatic wait_motor(input logic v, input int n);
        int i;
        for (i = 0; i < n && motor_drive !== v; i++) begin
            step(1);
        end
        check(32'(motor_drive), 32'(v));
    endtask : wait_motor

    // request a step, let the actuator settle, check where it stopped
    task automatic move(input logic med, input logic hard,
                        input dmac_pkg::dmac_pos_t exp_pos,
                        input logic [2:0] exp_idx);
        auto_req.medium_req = med;
        auto_req.hard_req   = hard;
        wait_motor(1'b1, 10);
        wait_motor(1'b0, 600);
        step(4);
        check(32'(position), 32'(exp_pos));
        check(32'(idx), 32'(exp_idx));
        check(32'(motor_drive), 32'h0);
    endtask : move

    task automatic turn(input logic [1:0] ab, input logic exp_dir,
                        input logic [15:0] exp_cnt);
        {ph_a, ph_b} = ab;
        step(8);
        check(32'(steer.dir_right), 32'(exp_dir));
        check(32'(steer.edge_count), 32'(exp_cnt));
    endtask : turn

    initial begin
        step(8);
        reset_n = 1'b1;
        step(6);
        check(32'(mode_a), 32'h0);
        check(32'(lamps), 32'h2);
        check(32'(fault), 32'h0);
        check(32'(position), 32'(dmac_pkg::DMAC_POS_SOFT));
        check(32'(motor_drive), 32'h0);
        // soft to the first hard, then medium, then hard wins over medium
        move(1'b0, 1'b1, dmac_pkg::DMAC_POS_HARD, 3'h1);
        move(1'b1, 1'b0, dmac_pkg::DMAC_POS_MEDIUM, 3'h2);
        move(1'b1, 1'b1, dmac_pkg::DMAC_POS_HARD, 3'h3);
        // back to soft passes through the undefined code still driving
        auto_req = '0;
        wait_motor(1'b1, 10);
        for (int i = 0; i < 200 && idx !== 3'h4; i++) begin
            step(1);
        end
        step(10);
        check(32'(position), 32'(dmac_pkg::DMAC_POS_UNDEF));
        check(32'(motor_drive), 32'h1);
        wait_motor(1'b0, 200);
        step(4);
        check(32'(position), 32'(dmac_pkg::DMAC_POS_SOFT));
        // a short bounce is far below the debounce time
        mode_switch = 1'b1;
        step(DEB / 4);
        mode_switch = 1'b0;
        step(20);
        check(32'(mode_a), 32'h0);
        check(32'(lamps), 32'h2);
        // b leads a: right turn, then a leads b: left turn
        turn(2'h1, 1'b1, 16'h1);
        turn(2'h3, 1'b1, 16'h2);
        turn(2'h2, 1'b1, 16'h3);
        turn(2'h0, 1'b1, 16'h4);
        turn(2'h2, 1'b0, 16'h5);
        turn(2'h3, 1'b0, 16'h6);
        // low clock enable freezes the decoder; it catches up afterwards
        clock_en = 1'b0;
        ph_a = 1'b0;
        step(8);
        check(32'(steer.edge_count), 32'h6);
        clock_en = 1'b1;
        turn(2'h1, 1'b0, 16'h7);
        // a held press goes to mode_a, which parks the actuator at hard
        mode_switch = 1'b1;
        step(2 * DEB);
        check(32'(mode_a), 32'h1);
        mode_switch = 1'b0;
        wait_motor(1'b0, 600);
        step(4);
        check(32'(lamps), 32'h1);
        check(32'(position), 32'(dmac_pkg::DMAC_POS_HARD));
        // back to touring, then jam the shaft on the undefined code
        mode_switch = 1'b1;
        step(2 * DEB);
        check(32'(mode_a), 32'h0);
        mode_switch = 1'b0;
        for (int i = 0; i < 400 && idx !== 3'h4; i++) begin
            step(1);
        end
        stuck = 1'b1;
        wait_motor(1'b0, UNDEF + 20);
        check(32'(fault), 32'h1);
        // a press in fault changes mode but the lamps keep blinking
        mode_switch = 1'b1;
        step(2 * DEB);
        mode_switch = 1'b0;
        check(32'(mode_a), 32'h1);
        check(32'(lamps), 32'h3);
        check(32'(motor_drive), 32'h0);
        step(BLINK / 2 - 5);
        check(32'(lamps), 32'h0);
        step(BLINK);
        check(32'(lamps), 32'h3);
        check(32'(fault), 32'h1);
        // second reset in mode_a mode: touring again, no drive
        stuck = 1'b0;
        reset_n = 1'b0;
        step(2);
        reset_n = 1'b1;
        step(1);
        check(32'(lamps), 32'h2);
        check(32'(motor_drive), 32'h0);
        step(1);
        check(32'(motor_drive), 32'h0);
        check(32'(mode_a), 32'h0);
        check(32'(fault), 32'h0);
        // a jammed shaft runs into the drive time limit
        stuck = 1'b1;
        auto_req.hard_req = 1'b1;
        wait_motor(1'b1, 10);
        wait_motor(1'b0, DRV + 20);
        check(32'(fault), 32'h1);
        stuck = 1'b0;
        step(DRV / 2);
        check(32'(motor_drive), 32'h0);
        check(32'(fault), 32'h1);
        fault_clear = 1'b1;
        step(1);
        fault_clear = 1'b0;
        move(1'b0, 1'b1, dmac_pkg::DMAC_POS_HARD, 3'h1);
        check(32'(fault), 32'h0);
        finish_test();
    end
endmodule : damping_mode_actuator_control_test
`default_nettype wire
